//--- verilog/config_prog_port.sv
// Serial programming port of the embedded configuration memory.
// Assumes the open-drain data wire is resolved outside from the enable.
//
// What this block does
// - Serial traffic is served only while programming_mode_select_n is low.
// - One data wire carries commands and data, driven by the sender.
// - Every message opens with a start and closes with a stop.
// - Each byte is eight data bit periods plus one acknowledge period.
// - The receiver of a byte drives its acknowledge.
// - While secured, every command but erase is left unacknowledged.
// - While secured, no stored byte is sent out over the serial wire.
// - A secured memory is reprogrammed only after a full erase.
// - The power-up load stays off the serial pins.
// - Clearing security goes with erasing the whole array.
// - Unsecured, programming and readback both work over the port.
// - The security bit is a stored cell set over the serial pins.
// - At power-up the array is copied to logic and processor memory.
// - Start is data falling with clock high; stop is data rising.
// - Bytes travel least significant bit first.
// - Writes wrap inside a 128 byte page on the low seven bits.
// - After a write stop, a timed cycle runs with nothing acknowledged.
`timescale 1ns/10ps
`include "prog_port_consts.svh"

module config_prog_port #(
	parameter int unsigned WRITE_CYCLES = `WRITE_CYCLES,
	parameter int unsigned ARRAY_BYTES = `ARRAY_BYTES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic config_serial_clock,
	input wire logic programming_mode_select_n,
	input wire logic config_serial_data_in,
	output logic config_serial_data_out,
	output logic config_serial_data_oe,
	output logic security_active,
	output logic boot_valid,
	output logic [`ADDR_BITS-1:0] boot_addr,
	output logic [7:0] boot_data,
	output logic boot_done
);

	localparam logic [3:0] sync_init = `SYNC_INIT;

	prog_port_pkg::state_t state;
	logic link_bit;
	logic link_toggle;
	logic [3:0] raw;
	logic [3:0] s1;
	logic [3:0] s2;
	logic [3:0] s3;
	logic [3:0] filt;
	logic [3:0] filt_d;
	logic mode_on;
	logic scl_fall;
	logic start;
	logic stop;
	logic bit_ev;
	logic serving;
	logic [3:0] bitcnt;
	logic [7:0] rx;
	logic mack;
	logic [`ADDR_BITS-1:0] addr;
	logic wrote;
	logic sec;
	logic ack_take;
	logic byte_end;
	logic ser_wr;
	logic sec_set;
	logic walking;
	logic last_walk;
	logic last_busy;
	logic [31:0] count;
	logic [7:0] rd_data;
	logic sec_cell;
	logic mem_wr_en;
	logic [`ADDR_BITS-1:0] mem_wr_addr;
	logic [7:0] mem_wr_data;
	logic [`ADDR_BITS-1:0] mem_rd_addr;

	serial_bit_capture capture (
		.config_serial_clock(config_serial_clock),
		.rst(rst),
		.config_serial_data_in(config_serial_data_in),
		.bit_value(link_bit),
		.bit_toggle(link_toggle)
	);

	config_mem_array array (
		.clk(clk),
		.wr_en(mem_wr_en),
		.wr_addr(mem_wr_addr),
		.wr_data(mem_wr_data),
		.rd_addr(mem_rd_addr),
		.rd_data(rd_data),
		.sec_wr_en(sec_set | last_walk),
		.sec_wr_value(sec_set),
		.sec_cell(sec_cell)
	);

	// Clock, data, mode select and the capture toggle each pass three stages.
	assign raw = {link_toggle, programming_mode_select_n,
		config_serial_data_in, config_serial_clock};

	genvar g;
	for (g = 0; g < 4; g++) begin : g_sync
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				s1[g] <= sync_init[g];
				s2[g] <= sync_init[g];
				s3[g] <= sync_init[g];
				filt[g] <= sync_init[g];
				filt_d[g] <= sync_init[g];
			end else begin
				s1[g] <= raw[g];
				s2[g] <= s1[g];
				s3[g] <= s2[g];
				if (s2[g] == s3[g]) begin
					filt[g] <= s3[g];
				end
				filt_d[g] <= filt[g];
			end
		end
	end

	assign mode_on = ~filt[2];
	assign scl_fall = filt_d[0] & ~filt[0];
	assign start = filt[0] & filt_d[0] & filt_d[1] & ~filt[1];
	assign stop = filt[0] & filt_d[0] & ~filt_d[1] & filt[1];
	assign bit_ev = filt[3] ^ filt_d[3];
	assign serving = mode_on && !(state inside {prog_port_pkg::ST_POWERUP,
		prog_port_pkg::ST_BOOT, prog_port_pkg::ST_ERASE,
		prog_port_pkg::ST_BUSY});
	assign byte_end = serving && scl_fall && bitcnt == `BIT_ACK;
	assign ser_wr = byte_end && state == prog_port_pkg::ST_WDATA && !sec;
	assign sec_set = serving && stop && state == prog_port_pkg::ST_SECWAIT;
	assign walking = state inside {prog_port_pkg::ST_BOOT,
		prog_port_pkg::ST_ERASE};
	assign last_walk = state == prog_port_pkg::ST_ERASE &&
		count == ARRAY_BYTES - 1;
	assign last_busy = state == prog_port_pkg::ST_BUSY &&
		count == WRITE_CYCLES - 1;

	// Decides whether the byte just received is acknowledged.
	always_comb begin
		ack_take = 1'b0;
		case (state)
			prog_port_pkg::ST_DEV: begin
				if (sec) begin
					ack_take = rx == {`DEV_ERASE, 1'b0};
				end else begin
					ack_take = rx[7:1] == `DEV_PROG ||
						rx == {`DEV_ERASE, 1'b0} ||
						rx == {`DEV_SECURE, 1'b0};
				end
			end
			prog_port_pkg::ST_ADDR2, prog_port_pkg::ST_ADDR1,
			prog_port_pkg::ST_ADDR0, prog_port_pkg::ST_WDATA: begin
				ack_take = !sec;
			end
			default: begin
				ack_take = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bitcnt <= 4'h0;
		end else if (!serving || start || stop) begin
			bitcnt <= 4'h0;
		end else if (bit_ev && bitcnt < `BIT_END) begin
			bitcnt <= bitcnt + 4'h1;
		end else if (scl_fall && bitcnt == `BIT_END) begin
			bitcnt <= 4'h0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx <= 8'h00;
			mack <= 1'b1;
		end else if (serving && bit_ev) begin
			if (bitcnt < `BIT_ACK) begin
				rx[bitcnt[2:0]] <= link_bit;
			end else if (bitcnt == `BIT_ACK) begin
				mack <= link_bit;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			addr <= '0;
		end else if (byte_end) begin
			case (state)
				prog_port_pkg::ST_ADDR2: begin
					addr[`ADDR_BITS-1] <= rx[0];
				end
				prog_port_pkg::ST_ADDR1: begin
					addr[15:8] <= rx;
				end
				prog_port_pkg::ST_ADDR0: begin
					addr[7:0] <= rx;
				end
				prog_port_pkg::ST_WDATA: begin
					if (!sec) begin
						addr[`PAGE_BITS-1:0] <=
							addr[`PAGE_BITS-1:0] + 7'h01;
					end
				end
				prog_port_pkg::ST_RDATA: begin
					addr <= addr + 17'h00001;
				end
				default: begin
					addr <= addr;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wrote <= 1'b0;
		end else if (start) begin
			wrote <= 1'b0;
		end else if (ser_wr) begin
			wrote <= 1'b1;
		end
	end

	// The wire is only ever pulled low; a one is sent by letting it go.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			config_serial_data_oe <= 1'b0;
		end else if (!serving || start || stop) begin
			config_serial_data_oe <= 1'b0;
		end else if (scl_fall) begin
			if (state == prog_port_pkg::ST_RDATA) begin
				if (bitcnt == `BIT_END) begin
					config_serial_data_oe <= !mack && !sec && !rd_data[0];
				end else if (bitcnt > 4'h0 && bitcnt < `BIT_ACK) begin
					config_serial_data_oe <= !sec && !rd_data[bitcnt[2:0]];
				end else begin
					config_serial_data_oe <= 1'b0;
				end
			end else if (bitcnt == `BIT_ACK) begin
				config_serial_data_oe <= ack_take;
			end else begin
				config_serial_data_oe <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count <= 32'h00000000;
		end else if (walking || state == prog_port_pkg::ST_BUSY) begin
			if ((walking && count == ARRAY_BYTES - 1) || last_busy) begin
				count <= 32'h00000000;
			end else begin
				count <= count + 32'h00000001;
			end
		end else begin
			count <= 32'h00000000;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sec <= 1'b1;
		end else if (state == prog_port_pkg::ST_POWERUP) begin
			sec <= sec_cell;
		end else if (sec_set) begin
			sec <= 1'b1;
		end else if (last_walk) begin
			sec <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= prog_port_pkg::ST_POWERUP;
		end else begin
			case (state)
				prog_port_pkg::ST_POWERUP: begin
					state <= prog_port_pkg::ST_BOOT;
				end
				prog_port_pkg::ST_BOOT: begin
					if (count == ARRAY_BYTES - 1) begin
						state <= prog_port_pkg::ST_IDLE;
					end
				end
				prog_port_pkg::ST_ERASE: begin
					if (last_walk) begin
						state <= prog_port_pkg::ST_BUSY;
					end
				end
				prog_port_pkg::ST_BUSY: begin
					if (last_busy) begin
						state <= prog_port_pkg::ST_IDLE;
					end
				end
				default: begin
					if (!mode_on) begin
						state <= prog_port_pkg::ST_IDLE;
					end else if (start) begin
						state <= prog_port_pkg::ST_DEV;
					end else if (stop) begin
						if (state == prog_port_pkg::ST_WDATA && wrote) begin
							state <= prog_port_pkg::ST_BUSY;
						end else if (state == prog_port_pkg::ST_SECWAIT) begin
							state <= prog_port_pkg::ST_BUSY;
						end else if (state == prog_port_pkg::ST_ERASEWAIT) begin
							state <= prog_port_pkg::ST_ERASE;
						end else begin
							state <= prog_port_pkg::ST_IDLE;
						end
					end else if (byte_end) begin
						case (state)
							prog_port_pkg::ST_DEV: begin
								if (!ack_take) begin
									state <= prog_port_pkg::ST_IGNORE;
								end else if (rx[7:1] == `DEV_ERASE) begin
									state <= prog_port_pkg::ST_ERASEWAIT;
								end else if (rx[7:1] == `DEV_SECURE) begin
									state <= prog_port_pkg::ST_SECWAIT;
								end else if (rx[0]) begin
									state <= prog_port_pkg::ST_RDATA;
								end else begin
									state <= prog_port_pkg::ST_ADDR2;
								end
							end
							prog_port_pkg::ST_ADDR2: begin
								state <= prog_port_pkg::ST_ADDR1;
							end
							prog_port_pkg::ST_ADDR1: begin
								state <= prog_port_pkg::ST_ADDR0;
							end
							prog_port_pkg::ST_ADDR0: begin
								state <= prog_port_pkg::ST_WDATA;
							end
							default: begin
								state <= state;
							end
						endcase
					end
				end
			endcase
		end
	end

	// The load stream is internal only; it never reaches the serial wire.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			boot_valid <= 1'b0;
			boot_addr <= '0;
			boot_done <= 1'b0;
		end else begin
			boot_valid <= state == prog_port_pkg::ST_BOOT;
			boot_addr <= count[`ADDR_BITS-1:0];
			if (state == prog_port_pkg::ST_BOOT && count == ARRAY_BYTES - 1) begin
				boot_done <= 1'b1;
			end
		end
	end

	assign boot_data = rd_data;
	assign config_serial_data_out = 1'b0;
	assign security_active = sec;
	assign mem_rd_addr = walking ? count[`ADDR_BITS-1:0] : addr;
	assign mem_wr_en = ser_wr || state == prog_port_pkg::ST_ERASE;
	assign mem_wr_addr = state == prog_port_pkg::ST_ERASE ?
		count[`ADDR_BITS-1:0] : addr;
	assign mem_wr_data = state == prog_port_pkg::ST_ERASE ? 8'h00 : rx;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_rx_ack;
		serving && scl_fall && bitcnt == `BIT_ACK &&
			state != prog_port_pkg::ST_RDATA && ack_take;
	endsequence

	sequence s_erase_end;
		last_walk;
	endsequence

	a_mode_off_quiet: assert property (!mode_on |=> !config_serial_data_oe)
		else $error("data wire driven outside programming mode");
	a_ack_driven: assert property (s_rx_ack |=> config_serial_data_oe)
		else $error("received byte not acknowledged");
	a_ack_released: assert property (serving && scl_fall &&
		bitcnt == `BIT_END && state != prog_port_pkg::ST_RDATA
		|=> !config_serial_data_oe)
		else $error("acknowledge held past its bit period");
	a_secure_erase_only: assert property (sec && byte_end &&
		state == prog_port_pkg::ST_DEV && rx != {`DEV_ERASE, 1'b0}
		|=> !config_serial_data_oe)
		else $error("secured port acknowledged a non-erase command");
	a_secure_no_read: assert property (sec |->
		state != prog_port_pkg::ST_RDATA)
		else $error("read path open while secured");
	a_busy_silent: assert property (state inside {prog_port_pkg::ST_BUSY,
		prog_port_pkg::ST_ERASE} |=> !config_serial_data_oe)
		else $error("wire driven during internal write cycle");
	a_page_wrap: assert property (ser_wr |=>
		addr[`ADDR_BITS-1:`PAGE_BITS] == $past(addr[`ADDR_BITS-1:`PAGE_BITS]) &&
		addr[`PAGE_BITS-1:0] == $past(addr[`PAGE_BITS-1:0]) + 7'h01)
		else $error("write address left its page");
	a_lsb_first: assert property (serving && bit_ev && bitcnt < `BIT_ACK &&
		!start && !stop |=> rx[$past(bitcnt[2:0])] == $past(link_bit))
		else $error("bit stored at wrong position");
	a_erase_clears: assert property (s_erase_end |=>
		!sec ##1 !sec_cell)
		else $error("erase did not clear the security cell");
	a_secure_set: assert property (sec_set |=> sec ##1 sec_cell)
		else $error("security cell not set");
	a_powerup_first: assert property (state == prog_port_pkg::ST_POWERUP
		|=> state == prog_port_pkg::ST_BOOT ##1 boot_valid)
		else $error("power-up order broken");
	a_start_frames: assert property (serving && start |=>
		state == prog_port_pkg::ST_DEV && bitcnt == 4'h0)
		else $error("start did not resynchronise the port");

endmodule

//--- shared/prog_port_consts.svh
// Constants of the configuration memory serial programming port.
// Assumes a 250 MHz core clock and a 1 Mbit byte-wide array.
`ifndef PROG_PORT_CONSTS_SVH
`define PROG_PORT_CONSTS_SVH

`define ADDR_BITS 17
`define PAGE_BITS 7
`define ARRAY_BYTES 131072
`define CLK_MHZ 250
`define WRITE_TIME_MS 20
`define WRITE_CYCLES (`WRITE_TIME_MS * 1000 * `CLK_MHZ)
`define BIT_ACK 4'h8
`define BIT_END 4'h9
`define SYNC_INIT 4'h7
`define DEV_PROG 7'h5A
`define DEV_ERASE 7'h5B
`define DEV_SECURE 7'h5C

`endif

//--- shared/prog_port_pkg.sv
// Types of the configuration memory serial programming port.
// Assumes nothing beyond a SystemVerilog compiler.
package prog_port_pkg;

	typedef enum logic [3:0] {
		ST_POWERUP,
		ST_BOOT,
		ST_IDLE,
		ST_DEV,
		ST_ADDR2,
		ST_ADDR1,
		ST_ADDR0,
		ST_WDATA,
		ST_RDATA,
		ST_SECWAIT,
		ST_ERASEWAIT,
		ST_IGNORE,
		ST_ERASE,
		ST_BUSY
	} state_t;

endpackage

//--- verilog/serial_bit_capture.sv
// Samples the data wire on each rising edge of the programmer's clock.
// Assumes the core side takes the held bit when the toggle has crossed.
`timescale 1ns/10ps

module serial_bit_capture (
	input wire logic config_serial_clock,
	input wire logic rst,
	input wire logic config_serial_data_in,
	output logic bit_value,
	output logic bit_toggle
);

	// The bit stays put until the next rising edge, at least 240 ns on in the bench.
	always_ff @(posedge config_serial_clock or posedge rst) begin
		if (rst) begin
			bit_value <= 1'b0;
			bit_toggle <= 1'b0;
		end else begin
			bit_value <= config_serial_data_in;
			bit_toggle <= ~bit_toggle;
		end
	end

endmodule

//--- verilog/config_mem_array.sv
// Byte array and security cell standing in for the nonvolatile memory.
// Assumes one write and one registered read per clock; rst never clears it.
`timescale 1ns/10ps
`include "prog_port_consts.svh"

module config_mem_array (
	input wire logic clk,
	input wire logic wr_en,
	input wire logic [`ADDR_BITS-1:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic [`ADDR_BITS-1:0] rd_addr,
	output logic [7:0] rd_data,
	input wire logic sec_wr_en,
	input wire logic sec_wr_value,
	output logic sec_cell
);

	logic [7:0] cells [0:`ARRAY_BYTES-1];
	logic sec_store;

	// The cells come up blank, as shipped, and keep their content over rst.
	initial begin
		for (int i = 0; i < `ARRAY_BYTES; i++) begin
			cells[i] = 8'h00;
		end
		sec_store = 1'b0;
	end

	always @(posedge clk) begin
		if (wr_en) begin
			cells[wr_addr] <= wr_data;
		end
		if (sec_wr_en) begin
			sec_store <= sec_wr_value;
		end
	end

	always_ff @(posedge clk) begin
		rd_data <= cells[rd_addr];
		sec_cell <= sec_store;
	end

endmodule

//--- verification/prog_model.sv
// Behavioural programmer that masters the two-wire programming link.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/10ps

module prog_model #(
	parameter int HALF = 20
) (
	output logic config_serial_clock,
	output logic pull_low,
	input wire logic wire_level
);
	logic tick;

	// Link timing runs off its own 6 ns clock, unrelated to the core clock.
	initial begin
		tick = 1'b0;
		#1.3;
		forever #3 tick = ~tick;
	end

	initial begin
		config_serial_clock = 1'b1;
		pull_low = 1'b0;
	end

	task automatic w(input int n);
		repeat (n) @(posedge tick);
	endtask

	task automatic start();
		pull_low = 1'b0;
		w(HALF);
		config_serial_clock = 1'b1;
		w(HALF);
		pull_low = 1'b1;
		w(HALF);
		config_serial_clock = 1'b0;
	endtask

	// The clock stands high between frames.
	task automatic stop();
		pull_low = 1'b1;
		w(HALF);
		config_serial_clock = 1'b1;
		w(HALF);
		pull_low = 1'b0;
		w(HALF);
	endtask

	// Data changes only while the clock is low and is sampled while high.
	task automatic bit_xfer(input logic b, output logic s);
		w(HALF / 2);
		pull_low = !b;
		w(HALF / 2);
		config_serial_clock = 1'b1;
		w(HALF / 2);
		s = wire_level;
		w(HALF / 2);
		config_serial_clock = 1'b0;
	endtask

	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 0; i < 8; i++) begin
			bit_xfer(b[i], s);
		end
		bit_xfer(1'b1, s);
		ack = !s;
	endtask

	task automatic recv_byte(output logic [7:0] b, input logic nack);
		logic s;
		for (int i = 0; i < 8; i++) begin
			bit_xfer(1'b1, s);
			b[i] = s;
		end
		bit_xfer(nack, s);
	endtask
endmodule

//--- verification/config_prog_port_bench.sv
// Self-checking bench for the configuration memory programming port.
// Assumes the port, the programmer model and a pulled-up data wire.
`timescale 1ns/10ps
`include "prog_port_consts.svh"

module config_prog_port_bench;
	localparam int unsigned WC = 2000;
	localparam int unsigned AB = 256;

	typedef struct {
		logic mode_n;
		logic [7:0] dev;
		logic ack;
	} row_t;

	logic clk;
	logic rst;
	logic programming_mode_select_n;
	logic config_serial_clock;
	logic pull_low;
	logic sda;
	logic data_out;
	logic data_oe;
	logic security_active;
	logic boot_valid;
	logic [`ADDR_BITS-1:0] boot_addr;
	logic [7:0] boot_data;
	logic boot_done;
	logic [7:0] mem [0:255];
	int err_total;
	int compares;
	row_t rows [6];

	// The wire is low if either party pulls; otherwise the pull-up wins.
	assign sda = !(pull_low || (data_oe && !data_out));

	config_prog_port #(.WRITE_CYCLES(WC), .ARRAY_BYTES(AB)) u_config_prog_port (
		.clk(clk), .rst(rst),
		.config_serial_clock(config_serial_clock),
		.programming_mode_select_n(programming_mode_select_n),
		.config_serial_data_in(sda), .config_serial_data_out(data_out),
		.config_serial_data_oe(data_oe), .security_active(security_active),
		.boot_valid(boot_valid), .boot_addr(boot_addr),
		.boot_data(boot_data), .boot_done(boot_done)
	);

	prog_model #(.HALF(20)) u_prog_model (
		.config_serial_clock(config_serial_clock),
		.pull_low(pull_low),
		.wire_level(sda)
	);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic results();
		if (err_total == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	task automatic send(input logic [7:0] b, input logic exp);
		logic a;
		u_prog_model.send_byte(b, a);
		check(32'(a), 32'(exp));
	endtask

	task automatic rd(input logic [7:0] exp, input logic nack);
		logic [7:0] b;
		u_prog_model.recv_byte(b, nack);
		check(32'(b), 32'(exp));
	endtask

	// Address bytes go most significant first; bit 0 of the first is A16.
	task automatic set_addr(input logic [16:0] a);
		u_prog_model.start();
		send(8'hB4, 1'b1);
		send({7'h00, a[16]}, 1'b1);
		send(a[15:8], 1'b1);
		send(a[7:0], 1'b1);
	endtask

	task automatic do_reset(input logic sec);
		int n;
		n = 0;
		@(posedge clk);
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		check(32'(security_active), 32'h1);
		check(32'(data_oe), 32'h0);
		check(32'(data_out), 32'h0);
		@(posedge clk);
		rst <= 1'b0;
		for (int t = 0; t < 4 * AB && boot_done !== 1'b1; t++) begin
			@(posedge clk);
			#1;
			check(32'(data_oe), 32'h0);
			if (boot_valid === 1'b1) begin
				check(32'(boot_addr), n);
				check(32'(boot_data), 32'(mem[n]));
				n++;
			end
		end
		check(n, AB);
		check(32'(boot_done), 32'h1);
		check(32'(security_active), 32'(sec));
		repeat (500) @(posedge clk);
	endtask

	initial begin
		#400000;
		err_total++;
		results();
	end

	initial begin
		rst = 1'b1;
		programming_mode_select_n = 1'b1;
		err_total = 0;
		compares = 0;
		foreach (mem[i]) mem[i] = 8'h00;
		rows = '{'{1'b1, 8'hB4, 1'b0}, '{1'b0, 8'hB4, 1'b1},
			'{1'b0, 8'hB6, 1'b1}, '{1'b0, 8'hB8, 1'b1},
			'{1'b0, 8'hA0, 1'b0}, '{1'b0, 8'hFF, 1'b0}};
		do_reset(1'b0);
		foreach (rows[i]) begin
			@(posedge clk);
			programming_mode_select_n <= rows[i].mode_n;
			repeat (10) @(posedge clk);
			u_prog_model.start();
			send(rows[i].dev, rows[i].ack);
		end
		u_prog_model.stop();
		// A write that runs off the page end wraps to the page start.
		set_addr(17'h0007E);
		send(8'h11, 1'b1);
		send(8'h22, 1'b1);
		send(8'h33, 1'b1);
		u_prog_model.stop();
		mem[8'h7E] = 8'h11;
		mem[8'h7F] = 8'h22;
		mem[8'h00] = 8'h33;
		u_prog_model.start();
		send(8'hB4, 1'b0);
		repeat (WC + 50) @(posedge clk);
		set_addr(17'h0007E);
		u_prog_model.start();
		send(8'hB5, 1'b1);
		rd(8'h11, 1'b0);
		rd(8'h22, 1'b0);
		rd(8'h00, 1'b1);
		u_prog_model.stop();
		set_addr(17'h00000);
		u_prog_model.start();
		send(8'hB5, 1'b1);
		rd(8'h33, 1'b1);
		u_prog_model.stop();
		do_reset(1'b0);
		u_prog_model.start();
		send(8'hB8, 1'b1);
		u_prog_model.stop();
		repeat (WC + 50) @(posedge clk);
		check(32'(security_active), 32'h1);
		u_prog_model.start();
		send(8'hB4, 1'b0);
		u_prog_model.start();
		send(8'hB5, 1'b0);
		u_prog_model.stop();
		do_reset(1'b1);
		u_prog_model.start();
		send(8'hB6, 1'b1);
		u_prog_model.stop();
		foreach (mem[i]) mem[i] = 8'h00;
		repeat (AB + WC + 100) @(posedge clk);
		check(32'(security_active), 32'h0);
		set_addr(17'h0007E);
		u_prog_model.start();
		send(8'hB5, 1'b1);
		rd(8'h00, 1'b1);
		u_prog_model.stop();
		results();
	end
endmodule
